// >>> logic/cfg_checksum.sv
// Purpose: serial checksum over a latched snapshot of the configuration
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   one bit per clock, done pulses once at the end
`timescale 1ns/100ps
`default_nettype none
module cfg_checksum
  import run_ctl_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  resetn_in,
  input  wire logic                  start_in,
  input  wire logic [CRC_DATA_W-1:0] data_in,
  output logic                       busy_out,
  output logic                       done_out,
  output logic      [CRC_W-1:0]      crc_out
);
  logic [CRC_DATA_W-1:0] shreg, next_shreg;
  logic [5:0]            cnt, next_cnt;
  logic [CRC_W-1:0]      crc, next_crc;
  logic                  busy, next_busy, done, next_done;
  logic                  fb;

  always_comb begin
    next_shreg = shreg;
    next_cnt   = cnt;
    next_crc   = crc;
    next_busy  = busy;
    next_done  = 1'b0;
    fb         = crc[CRC_W-1] ^ shreg[CRC_DATA_W-1];
    if (!busy && start_in) begin
      next_shreg = data_in;
      next_cnt   = 6'(CRC_DATA_W - 1);
      next_crc   = CRC_INIT;
      next_busy  = 1'b1;
    end else if (busy) begin
      next_crc   = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      next_shreg = {shreg[CRC_DATA_W-2:0], 1'b0};
      next_cnt   = cnt - 6'h01;
      if (cnt == 6'h00) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shreg <= '0;
      cnt   <= '0;
      crc   <= CRC_INIT;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      shreg <= next_shreg;
      cnt   <= next_cnt;
      crc   <= next_crc;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  assign busy_out = busy;
  assign done_out = done;
  assign crc_out  = crc;
endmodule
`default_nettype wire

// >>> logic/run_ctl_pkg.sv
// Purpose: shared constants and carriers for switch monitor run control
// Assumes: 100 MHz system clock, 24-bit configuration word
// Notes:   all reset values of the configuration word are zero
package run_ctl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_US         = 1000;

  localparam int unsigned CFG_W       = 24;
  localparam int unsigned CRC_W       = 8;
  localparam int unsigned CRC_DATA_W  = 2 * CFG_W;
  localparam int unsigned US_CNT_W    = 23;
  localparam int unsigned PRE_CNT_W   = 16;

  localparam int unsigned BIT_INT_SCHEME = 12;
  localparam int unsigned BIT_RUN        = 11;
  localparam int unsigned BIT_POLL_EN    = 10;
  localparam int unsigned BIT_CRC_REQ    = 9;
  localparam int unsigned WIN_LSB        = 5;
  localparam int unsigned PER_LSB        = 1;
  localparam int unsigned BIT_SW_RESET   = 0;

  localparam logic [CFG_W-1:0] CFG_RESET = 24'h000000;
  localparam logic [CFG_W-1:0] CCP_RESET = 24'h000000;
  // bits a running device still accepts
  localparam logic [CFG_W-1:0] RUN_WR_MASK = 24'h000a01;

  localparam int unsigned WIN_STEP_US     = 64;
  localparam int unsigned WIN_LONG_US     = 640;
  localparam int unsigned WIN_LONG_STEP   = 128;
  localparam int unsigned WIN_MAX_US      = 2048;
  localparam int unsigned WIN_DEFAULT_US  = 512;
  localparam int unsigned PER_BASE_MS     = 2;
  localparam int unsigned PER_CODE5_MS    = 48;
  localparam int unsigned PER_CODE6_MS    = 64;
  localparam int unsigned PER_DEFAULT_MS  = 8;

  localparam int unsigned DYN_PULSE_US  = 1;
  localparam int unsigned DYN_PULSE_CYC = DYN_PULSE_US * CYC_PER_US;

  localparam logic [CRC_W-1:0] CRC_POLY = 8'h2f;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'hff;

  typedef enum logic {INT_STATIC, INT_DYNAMIC} int_scheme_t;

  typedef struct packed {
    logic wetting_on;
    logic sample;
    logic running;
    logic crc_busy;
    logic checksum_done_flag;
    logic switch_flag;
  } run_status_t;
endpackage

// >>> logic/switch_monitor_run_control.sv
// Purpose: run control, sampling timer, checksum and interrupt pin
// Assumes: register writes arrive decoded from the serial port
// Notes:   soft reset pulses the cycle after the write and clears all state except the checksum engine one cycle later
//
// What this block does
// - bit 12 picks static (0) or dynamic (1) interrupt-pin scheme.
// - writing 1 to bit 11 starts wetting current and polling.
// - clearing bit 11 stops operation; device idles until set again.
// - while running only bits 11, 9, 0 and cleaning register take writes.
// - bit 10 zero means continuous mode, one means polling mode.
// - writing 1 to bit 9 starts a checksum over all configuration bits.
// - checksum end sets the done flag and pulls the interrupt pin low.
// - the checksum result is readable in its own register.
// - bit 9 clears itself once the checksum has run.
// - bits 4-1 select the polling period in milliseconds.
// - writing 1 to bit 0 resets the device except the checksum engine; 0 does nothing.
`timescale 1ns/100ps
`default_nettype none
module switch_monitor_run_control
  import run_ctl_pkg::*;
#(
  parameter int unsigned US_CYCLES = CYC_PER_US
)(
  input  wire logic              clk_sys_in,
  input  wire logic              resetn_in,
  input  wire logic              cfg_wr_in,
  input  wire logic [CFG_W-1:0]  cfg_wdata_in,
  input  wire logic              ccp_wr_in,
  input  wire logic [CFG_W-1:0]  ccp_wdata_in,
  input  wire logic              flag_clr_in,
  input  wire logic              sw_event_in,
  output logic      [CFG_W-1:0]  cfg_rdata_out,
  output logic      [CFG_W-1:0]  ccp_rdata_out,
  output logic      [CRC_W-1:0]  crc_rdata_out,
  output run_ctl_pkg::run_status_t status_out,
  output logic                   sw_reset_out,
  output logic                   int_n_out
);
  import run_ctl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_REST} run_state_t;

  function automatic logic [US_CNT_W-1:0] win_us(input logic [3:0] c);
    int unsigned v;
    if (c <= 4'h7)      v = (int'(c) + 1) * WIN_STEP_US;
    else if (c <= 4'hb) v = WIN_LONG_US + (int'(c) - 8) * WIN_LONG_STEP;
    else if (c == 4'hc) v = WIN_MAX_US;
    else                v = WIN_DEFAULT_US;
    return US_CNT_W'(v);
  endfunction

  function automatic logic [US_CNT_W-1:0] per_us(input logic [3:0] c);
    int unsigned v;
    if (c <= 4'h4)      v = PER_BASE_MS << c;
    else if (c == 4'h5) v = PER_CODE5_MS;
    else if (c <= 4'hc) v = PER_CODE6_MS << (int'(c) - 6);
    else                v = PER_DEFAULT_MS;
    return US_CNT_W'(v * MS_US);
  endfunction

  logic [CFG_W-1:0] cfg, next_cfg, ccp, next_ccp;
  logic             swrst, next_swrst;
  logic             running, poll_en, crc_start;
  logic [CFG_W-1:0] wmask;
  // checksum engine handshake, read by the config group below
  logic             crc_busy, crc_done;
  logic [CRC_W-1:0] crc_val;

  assign running = cfg[BIT_RUN];
  assign poll_en = cfg[BIT_POLL_EN];

  // config register group
  always_comb begin
    next_cfg   = cfg;
    next_ccp   = ccp;
    next_swrst = 1'b0;
    crc_start  = 1'b0;
    wmask      = running ? RUN_WR_MASK : '1;
    if (ccp_wr_in) begin
      next_ccp = ccp_wdata_in;
    end
    if (cfg_wr_in) begin
      next_cfg = (cfg & ~wmask) | (cfg_wdata_in & wmask);
      next_cfg[BIT_SW_RESET] = 1'b0;
      next_swrst = cfg_wdata_in[BIT_SW_RESET];
      crc_start  = cfg_wdata_in[BIT_CRC_REQ] && !cfg[BIT_CRC_REQ];
    end
    if (crc_done) begin
      next_cfg[BIT_CRC_REQ] = 1'b0;
    end
    if (swrst) begin
      next_cfg = CFG_RESET;
      next_ccp = CCP_RESET;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg   <= CFG_RESET;
      ccp   <= CCP_RESET;
      swrst <= 1'b0;
    end else begin
      cfg   <= next_cfg;
      ccp   <= next_ccp;
      swrst <= next_swrst;
    end
  end

  // sampling timer group
  run_state_t           st, next_st;
  logic [PRE_CNT_W-1:0] pre, next_pre;
  logic [US_CNT_W-1:0]  us_cnt, next_us_cnt;
  logic                 tick, smp, next_smp, wet, next_wet;

  assign tick = (pre == PRE_CNT_W'(US_CYCLES - 1));

  always_comb begin
    next_st     = st;
    next_pre    = tick ? '0 : pre + 1'b1;
    next_us_cnt = us_cnt;
    next_smp    = 1'b0;
    unique case (st)
      ST_IDLE: begin
        next_pre    = '0;
        next_us_cnt = '0;
        if (running) begin
          next_st = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (tick) begin
          next_us_cnt = us_cnt + 1'b1;
          if (us_cnt == win_us(cfg[WIN_LSB+:4]) - 1'b1) begin
            next_smp = 1'b1;
            if (poll_en) begin
              next_st = ST_REST;
            end else begin
              next_us_cnt = '0;
            end
          end
        end
      end
      ST_REST: begin
        if (tick) begin
          next_us_cnt = us_cnt + 1'b1;
          if (us_cnt >= per_us(cfg[PER_LSB+:4]) - 1'b1) begin
            next_st     = ST_ACTIVE;
            next_us_cnt = '0;
          end
        end
      end
    endcase
    if (!running || swrst) begin
      next_st     = ST_IDLE;
      next_smp    = 1'b0;
      next_pre    = '0;
      next_us_cnt = '0;
    end
    next_wet = (next_st == ST_ACTIVE);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st     <= ST_IDLE;
      pre    <= '0;
      us_cnt <= '0;
      smp    <= 1'b0;
      wet    <= 1'b0;
    end else begin
      st     <= next_st;
      pre    <= next_pre;
      us_cnt <= next_us_cnt;
      smp    <= next_smp;
      wet    <= next_wet;
    end
  end

  // checksum engine over both configuration words
  cfg_checksum u_checksum (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .start_in   (crc_start),
    .data_in    ({cfg, ccp}),
    .busy_out   (crc_busy),
    .done_out   (crc_done),
    .crc_out    (crc_val)
  );

  // flags, result and interrupt pin group
  logic             crc_flag, next_crc_flag, sw_flag, next_sw_flag;
  logic [CRC_W-1:0] crc_res, next_crc_res;
  logic [7:0]       dyn_cnt, next_dyn_cnt;
  logic             int_n, next_int_n, sw_evt, new_evt;

  assign sw_evt  = sw_event_in && running;
  assign new_evt = crc_done || sw_evt;

  always_comb begin
    next_crc_res  = crc_done ? crc_val : crc_res;
    // a new event beats a clear in the same cycle
    next_crc_flag = crc_done || (crc_flag && !flag_clr_in);
    next_sw_flag  = sw_evt || (sw_flag && !flag_clr_in);
    next_dyn_cnt  = (dyn_cnt != 8'h00) ? dyn_cnt - 8'h01 : 8'h00;
    if (new_evt) begin
      next_dyn_cnt = 8'(DYN_PULSE_CYC);
    end
    if (cfg[BIT_INT_SCHEME] == INT_STATIC) begin
      next_int_n = !(next_crc_flag || next_sw_flag);
    end else begin
      next_int_n = (next_dyn_cnt == 8'h00);
    end
    if (swrst) begin
      next_crc_res  = '0;
      next_crc_flag = 1'b0;
      next_sw_flag  = 1'b0;
      next_dyn_cnt  = '0;
      next_int_n    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crc_res  <= '0;
      crc_flag <= 1'b0;
      sw_flag  <= 1'b0;
      dyn_cnt  <= '0;
      int_n    <= 1'b1;
    end else begin
      crc_res  <= next_crc_res;
      crc_flag <= next_crc_flag;
      sw_flag  <= next_sw_flag;
      dyn_cnt  <= next_dyn_cnt;
      int_n    <= next_int_n;
    end
  end

  assign cfg_rdata_out = cfg;
  assign ccp_rdata_out = ccp;
  assign crc_rdata_out = crc_res;
  assign sw_reset_out  = swrst;
  assign int_n_out     = int_n;
  assign status_out    = '{wetting_on: wet, sample: smp, running: running,
                           crc_busy: crc_busy, checksum_done_flag: crc_flag,
                           switch_flag: sw_flag};

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence s_crc_req;
    cfg_wr_in && cfg_wdata_in[BIT_CRC_REQ] && !cfg[BIT_CRC_REQ] && !swrst;
  endsequence
  sequence s_crc_run;
    crc_busy [*8];
  endsequence

  property p_static_low;
    (!cfg[BIT_INT_SCHEME] && crc_done && !swrst) |=> !int_n_out;
  endproperty
  a_static_low: assert property (p_static_low)
    else $error("static scheme did not pull interrupt low");

  property p_dyn_pulse;
    (cfg[BIT_INT_SCHEME] && new_evt && !swrst) |=> !int_n_out;
  endproperty
  a_dyn_pulse: assert property (p_dyn_pulse)
    else $error("dynamic scheme gave no low pulse");

  property p_start;
    (st == ST_IDLE && running && !swrst) |=> (st == ST_ACTIVE) ##1 wet;
  endproperty
  a_start: assert property (p_start)
    else $error("run bit did not start the timer");

  property p_stop;
    !running |=> (st == ST_IDLE) && !wet;
  endproperty
  a_stop: assert property (p_stop)
    else $error("device not idle after run bit cleared");

  property p_locked;
    (running && cfg_wr_in && !swrst && !crc_done) |=>
      cfg[CFG_W-1:BIT_INT_SCHEME] == $past(cfg[CFG_W-1:BIT_INT_SCHEME]) &&
      cfg[BIT_POLL_EN:BIT_POLL_EN] == $past(cfg[BIT_POLL_EN:BIT_POLL_EN]) &&
      cfg[8:1] == $past(cfg[8:1]);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked bit changed while running");

  property p_continuous;
    (running && !poll_en) |-> st != ST_REST;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous mode entered rest phase");

  property p_crc_start;
    s_crc_req |=> s_crc_run;
  endproperty
  a_crc_start: assert property (p_crc_start)
    else $error("checksum did not run after request");

  property p_crc_result;
    (crc_done && !swrst) |=> crc_rdata_out == $past(crc_val) && crc_flag;
  endproperty
  a_crc_result: assert property (p_crc_result)
    else $error("checksum result or flag not captured");

  property p_crc_clear;
    (crc_done && !(cfg_wr_in && cfg_wdata_in[BIT_CRC_REQ])) |=>
      !cfg[BIT_CRC_REQ];
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("checksum request bit did not self clear");

  property p_swreset;
    (cfg_wr_in && cfg_wdata_in[BIT_SW_RESET]) |=> swrst ##1
      (cfg == CFG_RESET && int_n_out);
  endproperty
  a_swreset: assert property (p_swreset)
    else $error("software reset did not clear state");

  property p_idle_quiet;
    !running |=> !smp && !wet;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("activity while idle");
endmodule
`default_nettype wire

// >>> tb/host_model.sv
// Purpose: host controller model writing the run-control registers
// Assumes: strobes move on the falling clock edge, one idle cycle between
// Notes:   released write data is inverted so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module host_model
  import run_ctl_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic [CFG_W-1:0] cfg_rdata_in,
  output logic                  cfg_wr_out,
  output logic      [CFG_W-1:0] cfg_wdata_out,
  output logic                  ccp_wr_out,
  output logic      [CFG_W-1:0] ccp_wdata_out,
  output logic                  flag_clr_out
);
  initial begin
    cfg_wr_out = 1'b0;
    ccp_wr_out = 1'b0;
    flag_clr_out = 1'b0;
    cfg_wdata_out = 24'h000000;
    ccp_wdata_out = 24'h000000;
  end

  task automatic wr_cfg(input logic [CFG_W-1:0] d);
    @(negedge clk_sys_in);
    cfg_wr_out <= 1'b1;
    cfg_wdata_out <= d;
    @(negedge clk_sys_in);
    cfg_wr_out <= 1'b0;
    cfg_wdata_out <= ~d;
  endtask

  task automatic wr_ccp(input logic [CFG_W-1:0] d);
    @(negedge clk_sys_in);
    ccp_wr_out <= 1'b1;
    ccp_wdata_out <= d;
    @(negedge clk_sys_in);
    ccp_wr_out <= 1'b0;
    ccp_wdata_out <= ~d;
  endtask

  task automatic clr_flags;
    @(negedge clk_sys_in);
    flag_clr_out <= 1'b1;
    @(negedge clk_sys_in);
    flag_clr_out <= 1'b0;
  endtask

  // stop, reconfigure, start again: avoids false status on the fly
  task automatic restart(input logic [CFG_W-1:0] d);
    wr_cfg(cfg_rdata_in & 24'hfff7ff);
    wr_cfg(d & 24'hfff7ff);
    wr_cfg(d | 24'h000800);
  endtask

  // config left untouched until the request bit drops
  task automatic crc_req;
    wr_cfg(cfg_rdata_in | 24'h000200);
    repeat (300) if (cfg_rdata_in[BIT_CRC_REQ]) @(negedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the switch monitor run control
// Assumes: one microsecond tick per clock to keep runs short
// Notes:   expectations go through a queue read by a watcher process
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import run_ctl_pkg::*;
  localparam int unsigned USC = 1;
  typedef struct {int sel; logic [CFG_W-1:0] val;} note_t;

  logic              clk_sys_in, resetn_in, sw_event_in;
  logic              cfg_wr, ccp_wr, flag_clr, sw_rst, int_n;
  logic [CFG_W-1:0]  cfg_wd, ccp_wd, cfg_rd, ccp_rd, seen;
  logic [CRC_W-1:0]  crc_rd;
  run_status_t       st;
  note_t             notes[$];
  note_t             n;
  int                fails, checks_done, cyc, low_cyc;

  switch_monitor_run_control #(.US_CYCLES(USC)) dut_u (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .cfg_wr_in     (cfg_wr),
    .cfg_wdata_in  (cfg_wd),
    .ccp_wr_in     (ccp_wr),
    .ccp_wdata_in  (ccp_wd),
    .flag_clr_in   (flag_clr),
    .sw_event_in   (sw_event_in),
    .cfg_rdata_out (cfg_rd),
    .ccp_rdata_out (ccp_rd),
    .crc_rdata_out (crc_rd),
    .status_out    (st),
    .sw_reset_out  (sw_rst),
    .int_n_out     (int_n)
  );

  host_model host_u (
    .clk_sys_in    (clk_sys_in),
    .cfg_rdata_in  (cfg_rd),
    .cfg_wr_out    (cfg_wr),
    .cfg_wdata_out (cfg_wd),
    .ccp_wr_out    (ccp_wr),
    .ccp_wdata_out (ccp_wd),
    .flag_clr_out  (flag_clr)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic complete_run;
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [CFG_W-1:0] s, input logic [CFG_W-1:0] x);
    checks_done++;
    if (s !== x) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // sel 0 cfg, 1 ccp, 2 crc, 3 {int_n, status}, 4 soft reset
  task automatic note(input int sel, input logic [CFG_W-1:0] v);
    notes.push_back('{sel, v});
    @(negedge clk_sys_in);
  endtask

  // watcher reads values settled before this edge's updates land
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      complete_run;
    end
    if (notes.size() != 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: seen = cfg_rd;
        1: seen = ccp_rd;
        2: seen = CFG_W'(crc_rd);
        3: seen = CFG_W'({int_n, st});
        default: seen = CFG_W'(sw_rst);
      endcase
      check(seen, n.val); // tag sits on each noted expectation
    end
  end

  always @(negedge clk_sys_in) if (int_n === 1'b0) low_cyc++;

  function automatic int win_us(input int c);
    if (c < 8) return WIN_STEP_US * (c + 1);
    if (c < 12) return WIN_LONG_US + WIN_LONG_STEP * (c - 8);
    return (c == 12) ? WIN_MAX_US : WIN_DEFAULT_US;
  endfunction

  function automatic int per_ms(input int c);
    if (c < 5) return PER_BASE_MS << c;
    if (c == 5) return PER_CODE5_MS;
    return (c < 13) ? PER_CODE6_MS << (c - 6) : PER_DEFAULT_MS;
  endfunction

  task automatic pulse_evt;
    sw_event_in <= 1'b1;
    @(negedge clk_sys_in);
    sw_event_in <= 1'b0;
    @(negedge clk_sys_in);
  endtask

  // gap between two sample pulses and wetting cycles inside it
  task automatic meas(output int gap, output int wet);
    int k;
    gap = 0;
    wet = 0;
    k = 0;
    while (st.sample !== 1'b1 && k < 20000) begin
      @(negedge clk_sys_in);
      k++;
    end
    do begin
      @(negedge clk_sys_in);
      gap++;
      if (st.wetting_on === 1'b1) wet++;
    end while (st.sample !== 1'b1 && gap < 20000);
  endtask

  initial begin
    int gap, wet;
    int wc[4] = '{0, 12, 13, 9};
    int pc[4] = '{0, 1, 13, 0};
    logic [CFG_W-1:0] d, c, e;
    logic [CRC_W-1:0] r;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    low_cyc = 0;
    sw_event_in = 1'b0;
    resetn_in = 1'b0;
    void'($urandom(32'hcfd9));
    repeat (8) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    note(0, CFG_RESET);
    note(1, CCP_RESET);
    note(3, 24'h40);
    d = $urandom & 24'hfff5fe;
    c = $urandom;
    host_u.wr_cfg(d);
    note(0, d);
    note(4, 24'h0);
    host_u.wr_ccp(c);
    note(1, c);
    host_u.wr_cfg(d | 24'h000800);
    note(0, d | 24'h000800);
    e = ($urandom | 24'h000800) & 24'hfffdfe;
    host_u.wr_cfg(e);
    note(0, d | 24'h000800);
    c = $urandom;
    host_u.wr_ccp(c);
    note(1, c);
    check(CFG_W'(st.running), 24'h1);
    host_u.wr_cfg(d);
    repeat (3) @(negedge clk_sys_in);
    pulse_evt;
    e = 24'h0;
    repeat (3000) begin
      @(negedge clk_sys_in);
      if (st.sample === 1'b1 || st.wetting_on === 1'b1) e++;
    end
    check(e, 24'h0);
    note(3, 24'h40);
    for (int i = 0; i < 4; i++) begin
      host_u.restart((d & 24'hffe001) | 24'h400 | (wc[i] << 5) | (pc[i] << 1));
      meas(gap, wet);
      check(CFG_W'(gap), CFG_W'(per_ms(pc[i]) * MS_US * USC));
      check(CFG_W'(wet), CFG_W'(win_us(wc[i]) * USC));
    end
    host_u.restart((d & 24'hffe001) | (3 << 5));
    meas(gap, wet);
    check(CFG_W'(gap), CFG_W'(win_us(3) * USC));
    check(CFG_W'(wet), CFG_W'(gap));
    pulse_evt;
    check(CFG_W'({int_n, st.switch_flag}), 24'h1);
    host_u.clr_flags;
    @(negedge clk_sys_in);
    check(CFG_W'(int_n), 24'h1);
    host_u.crc_req;
    check(CFG_W'(cfg_rd[BIT_CRC_REQ]), 24'h0);
    check(CFG_W'({st.checksum_done_flag, int_n}), 24'h2);
    r = crc_rd;
    host_u.clr_flags;
    host_u.crc_req;
    note(2, CFG_W'(r));
    host_u.wr_ccp(c ^ 24'h000001);
    host_u.crc_req;
    check(CFG_W'(crc_rd !== r), 24'h1);
    host_u.clr_flags;
    host_u.restart((d & 24'hffe001) | 24'h001000);
    low_cyc = 0;
    host_u.crc_req;
    repeat (150) @(negedge clk_sys_in);
    check(CFG_W'({st.checksum_done_flag, int_n}), 24'h3);
    check(CFG_W'(low_cyc != 0), 24'h1);
    host_u.wr_cfg(cfg_rd | 24'h000001);
    note(4, 24'h1);
    note(0, 24'h0);
    note(1, 24'h0);
    repeat (3) @(negedge clk_sys_in);
    note(3, 24'h40);
    complete_run;
  end
endmodule
`default_nettype wire
